// file: verilog/asw_uart.sv
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module asw_uart
	import asw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rxd,
	output logic txd_o,
	output logic txd_oe
);
	logic acc;
	logic [9:0] idx;
	logic wr_pend_reg;
	logic [9:0] wr_idx_reg;
	logic wr_c1, wr_c2, wr_data, wr_baud;
	logic rd_stat, rd_data;
	logic [31:0] rd_word;
	logic [15:0] baud_div_reg;
	logic m_reg, wake_reg, t8_reg, r8_reg;
	logic sender_on_reg, re_reg, receiver_sleep_reg, sbk_reg;
	logic [7:0] tx_buf_reg;
	logic tx_full_reg;
	logic tc_reg;
	logic [7:0] serial_data_buffer_reg;
	logic receive_full_flag_reg, idle_flag_reg, overrun_reg;
	logic noise_flag_reg, framing_error_flag_reg, break_reg;
	logic [7:0] arm_reg;
	logic [7:0] stat;
	logic tick, take, tx_busy;
	logic rx_meta_reg, rx_sync_reg;
	asw_rx_e rx_state_reg;
	logic [3:0] ph_reg, bit_reg;
	logic [1:0] samp_reg;
	logic [8:0] sh_reg;
	logic noise_reg, high_seen_reg, active_reg;
	logic [7:0] idle_cnt_reg;
	logic [3:0] nbits;
	logic [7:0] frame_ticks;
	logic vote, vote_bad, vote_now;
	logic deliver, idle_hit, wake_addr, wake_idle, stop_ok;
	logic put_buf, set_or, set_nf, set_fe, set_idle, set_brk;
	logic tc_set;

	function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
		return a == b;
	endfunction

	// bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign acc = hsel && hready && htrans[1];
	assign idx = haddr[11:2];
	assign rd_stat = acc && !hwrite && hit(idx, IDX_STAT);
	assign rd_data = acc && !hwrite && hit(idx, IDX_DATA);
	assign wr_c1 = wr_pend_reg && hit(wr_idx_reg, IDX_CTRL1);
	assign wr_c2 = wr_pend_reg && hit(wr_idx_reg, IDX_CTRL2);
	assign wr_data = wr_pend_reg && hit(wr_idx_reg, IDX_DATA);
	assign wr_baud = wr_pend_reg && hit(wr_idx_reg, IDX_BAUD);

	assign stat = {!tx_full_reg, tc_reg, receive_full_flag_reg,
		idle_flag_reg, overrun_reg, noise_flag_reg,
		framing_error_flag_reg, 1'b0};

	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (hit(idx, IDX_BAUD))
			rd_word = {15'h0000, break_reg, baud_div_reg};
		else if (hit(idx, IDX_CTRL1))
			rd_word = {24'h00_0000, r8_reg, t8_reg, 1'b0, m_reg,
				wake_reg, 3'h0};
		else if (hit(idx, IDX_CTRL2))
			rd_word = {28'h000_0000, sender_on_reg, re_reg,
				receiver_sleep_reg, sbk_reg};
		else if (hit(idx, IDX_STAT))
			rd_word = {24'h00_0000, stat};
		else if (hit(idx, IDX_DATA))
			rd_word = {24'h00_0000, serial_data_buffer_reg};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 10'h000;
			hrdata <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_reg <= acc && hwrite;
			if (acc)
				wr_idx_reg <= idx;
			if (acc && !hwrite)
				hrdata <= rd_word;
		end
	end

	// a status read arms the flags it saw for clearing
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			arm_reg <= BYTE_RST;
		else if (rd_stat)
			arm_reg <= stat;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			baud_div_reg <= DIV_RST;
			m_reg <= 1'b0;
			wake_reg <= 1'b0;
			t8_reg <= 1'b0;
			sender_on_reg <= 1'b0;
			re_reg <= 1'b0;
			sbk_reg <= 1'b0;
		end
		else
		begin
			if (wr_baud)
				baud_div_reg <= hwdata[15:0];
			if (wr_c1)
			begin
				t8_reg <= hwdata[C1_T8];
				m_reg <= hwdata[C1_M]; // see (RULE6)
				wake_reg <= hwdata[C1_WAKE];
			end
			if (wr_c2)
			begin
				sender_on_reg <= hwdata[C2_TE];
				re_reg <= hwdata[C2_RE];
				sbk_reg <= hwdata[C2_SBK];
			end
		end
	end

	// software writes sleep; hardware clears it on wake
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			receiver_sleep_reg <= 1'b0;
		else if (wr_c2)
			receiver_sleep_reg <= hwdata[C2_SLEEP]; // see (RULE13)
		else if (wake_addr || wake_idle)
			receiver_sleep_reg <= 1'b0; // see (RULE13)
	end

	// transmit buffer: a new write wins over the take
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_buf_reg <= BYTE_RST;
			tx_full_reg <= 1'b0;
		end
		else if (wr_data)
		begin
			tx_buf_reg <= hwdata[7:0];
			tx_full_reg <= 1'b1;
		end
		else if (take)
			tx_full_reg <= 1'b0;
	end

	assign tc_set = !tx_busy && !tx_full_reg;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tc_reg <= 1'b1;
		else
			tc_reg <= tc_set || (tc_reg && !(wr_data && arm_reg[ST_TC]));
	end

	// one divider feeds both directions
	asw_baud u_baud (
		.hclk(hclk),
		.hresetn(hresetn),
		.div(baud_div_reg),
		.tick(tick) // see (RULE7)
	);

	asw_tx u_tx (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(tick),
		.sender_on(sender_on_reg),
		.sbk(sbk_reg),
		.nine(m_reg),
		.buf_full(tx_full_reg),
		.buf_data({t8_reg, tx_buf_reg}),
		.take(take),
		.busy(tx_busy),
		.txd_o(txd_o),
		.txd_oe(txd_oe)
	);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end
		else
		begin
			rx_meta_reg <= rxd;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	assign nbits = m_reg ? BITS9 : BITS8; // see (RULE17)
	assign frame_ticks = {nbits + 4'h2, 4'h0};
	assign vote_now = tick && rx_state_reg == RX_FRAME && ph_reg == PH_VOTE;
	assign vote = asw_maj3({samp_reg, rx_sync_reg}); // see (RULE11) (RULE21)
	assign vote_bad = !(samp_reg[0] == samp_reg[1]
		&& samp_reg[0] == rx_sync_reg); // see (RULE21)
	assign deliver = vote_now && bit_reg == nbits + 4'h1;
	assign stop_ok = vote;
	assign wake_addr = vote_now && bit_reg == nbits && vote
		&& wake_reg && receiver_sleep_reg; // see (RULE15) (RULE18) (RULE20)
	assign idle_hit = tick && rx_state_reg == RX_IDLE && rx_sync_reg
		&& idle_cnt_reg == frame_ticks - 8'h01; // see (RULE22)
	assign wake_idle = idle_hit && !wake_reg
		&& receiver_sleep_reg; // see (RULE14) (RULE18)

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_state_reg <= RX_IDLE;
			ph_reg <= 4'h0;
			bit_reg <= 4'h0;
			samp_reg <= 2'b11;
			sh_reg <= 9'h000;
			noise_reg <= 1'b0;
			high_seen_reg <= 1'b0;
		end
		else if (!re_reg)
		begin
			rx_state_reg <= RX_IDLE;
			high_seen_reg <= 1'b0;
		end
		else if (tick)
		begin
			case (rx_state_reg)
				RX_IDLE:
				begin
					ph_reg <= 4'h0;
					bit_reg <= 4'h0;
					noise_reg <= 1'b0;
					high_seen_reg <= rx_sync_reg;
					if (high_seen_reg && !rx_sync_reg)
						rx_state_reg <= RX_FRAME; // see (RULE2)
				end
				RX_FRAME:
				begin
					ph_reg <= ph_reg + 4'h1;
					if (ph_reg == OSR_LAST)
						bit_reg <= bit_reg + 4'h1;
					if (ph_reg == PH_S0 || ph_reg == PH_S1)
						samp_reg <= {samp_reg[0], rx_sync_reg};
					if (ph_reg == PH_VOTE)
					begin
						noise_reg <= noise_reg | vote_bad;
						if (bit_reg == 4'h0 && vote)
							rx_state_reg <= RX_IDLE;
						else if (bit_reg == nbits + 4'h1)
						begin
							rx_state_reg <= RX_IDLE; // see (RULE4)
							high_seen_reg <= vote;
						end
						else if (bit_reg != 4'h0)
							sh_reg <= {vote, sh_reg[8:1]}; // see (RULE3)
					end
				end
				default:
					rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// whole frame time of high line while not in a frame
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			idle_cnt_reg <= 8'h00;
			active_reg <= 1'b0;
		end
		else if (tick)
		begin
			if (!rx_sync_reg || rx_state_reg != RX_IDLE)
			begin
				idle_cnt_reg <= 8'h00;
				active_reg <= 1'b1;
			end
			else if (idle_cnt_reg != frame_ticks)
				idle_cnt_reg <= idle_cnt_reg + 8'h01;
			if (idle_hit)
				active_reg <= 1'b0;
		end
	end

	// flag sets; all held off while asleep
	assign put_buf = deliver && !receiver_sleep_reg
		&& !receive_full_flag_reg && !framing_error_flag_reg; // see (RULE12)
	assign set_or = deliver && !receiver_sleep_reg
		&& receive_full_flag_reg; // see (RULE12)
	assign set_nf = put_buf && (noise_reg || vote_bad);
	assign set_fe = put_buf && !stop_ok;
	// eight-bit frames leave a stale bit in sh_reg[0]
	assign set_brk = set_fe && (m_reg ? sh_reg == 9'h000
		: sh_reg[8:1] == 8'h00); // see (RULE5)
	assign set_idle = idle_hit && active_reg && !receiver_sleep_reg; // see (RULE12)

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			serial_data_buffer_reg <= BYTE_RST;
			r8_reg <= 1'b0;
		end
		else if (put_buf)
		begin
			// hand over the whole character at once
			serial_data_buffer_reg <= m_reg ? sh_reg[7:0]
				: sh_reg[8:1]; // see (RULE10)
			r8_reg <= m_reg & sh_reg[8];
		end
	end

	// set wins over the read-status, read-data clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			receive_full_flag_reg <= 1'b0;
			idle_flag_reg <= 1'b0;
			overrun_reg <= 1'b0;
			noise_flag_reg <= 1'b0;
			framing_error_flag_reg <= 1'b0;
			break_reg <= 1'b0;
		end
		else
		begin
			receive_full_flag_reg <= put_buf || (receive_full_flag_reg
				&& !(rd_data && arm_reg[ST_RECEIVE_FULL_FLAG]));
			idle_flag_reg <= set_idle || (idle_flag_reg
				&& !(rd_data && arm_reg[ST_IDLE]));
			overrun_reg <= set_or || (overrun_reg
				&& !(rd_data && arm_reg[ST_OR]));
			noise_flag_reg <= set_nf || (noise_flag_reg
				&& !(rd_data && arm_reg[ST_NF]));
			framing_error_flag_reg <= set_fe || (framing_error_flag_reg
				&& !(rd_data && arm_reg[ST_FE]));
			break_reg <= set_brk || (break_reg
				&& !(rd_data && arm_reg[ST_FE]));
		end
	end
endmodule // asw_uart
`default_nettype wire

// file: verilog/asw_pkg.sv
// How it works
// (RULE1) the line rests high whenever no frame is being sent
// (RULE2) a frame opens with one low start bit; a falling edge starts reception
// (RULE3) data bits travel least significant bit first
// (RULE4) a frame closes with one high stop bit
// (RULE5) a break is a whole low frame; it can be sent and recognised
// (RULE6) one word-size bit in control one sets both directions' length
// (RULE7) sender and receiver run apart but share format and bit rate
// (RULE8) the transmit shifter loads only from the transmit buffer
// (RULE9) the output pin is driven while sending or while sender_on is set
// (RULE10) a complete character moves in parallel to the receive buffer
// (RULE11) each bit is sampled several times and decided by majority
// (RULE12) while asleep no receive status flag may become set
// (RULE13) software writes the sleep bit; hardware clears it on wake-up
// (RULE14) idle-line mode wakes as soon as an idle line is seen
// (RULE15) address-mark mode wakes on a character whose top bit is one
// (RULE16) the sender leaves an idle frame between messages, none inside
// (RULE17) word-size zero gives eight data bits, one gives nine
// (RULE18) wake-select zero means idle-line, one means address-mark
// (RULE19) sender_on rising queues one character time of high preamble
// (RULE20) address-mark wake happens before the waking frame's stop bit
// (RULE21) sixteen samples per bit, vote over three at the centre
// (RULE22) idle means a whole frame time of continuous high line
`default_nettype none
package asw_pkg;
	localparam logic [9:0] IDX_BAUD = 10'h02b;
	localparam logic [9:0] IDX_CTRL1 = 10'h02c;
	localparam logic [9:0] IDX_CTRL2 = 10'h02d;
	localparam logic [9:0] IDX_STAT = 10'h02e;
	localparam logic [9:0] IDX_DATA = 10'h02f;
	localparam int C1_R8 = 7;
	localparam int C1_T8 = 6;
	localparam int C1_M = 4;
	localparam int C1_WAKE = 3;
	localparam int C2_TE = 3;
	localparam int C2_RE = 2;
	localparam int C2_SLEEP = 1;
	localparam int C2_SBK = 0;
	localparam int ST_TDRE = 7;
	localparam int ST_TC = 6;
	localparam int ST_RECEIVE_FULL_FLAG = 5;
	localparam int ST_IDLE = 4;
	localparam int ST_OR = 3;
	localparam int ST_NF = 2;
	localparam int ST_FE = 1;
	localparam int BD_BRK = 16;
	localparam logic [15:0] DIV_RST = 16'h0145;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] OSR_LAST = 4'hf;
	localparam logic [3:0] PH_S0 = 4'h7;
	localparam logic [3:0] PH_S1 = 4'h8;
	localparam logic [3:0] PH_VOTE = 4'h9;
	localparam logic [3:0] BITS8 = 4'h8;
	localparam logic [3:0] BITS9 = 4'h9;
	localparam logic [10:0] SH_IDLE = 11'h7ff;
	typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_FRAME = 2'b10} asw_rx_e;
	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} asw_tx_e;
	function automatic logic asw_maj3(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction
endpackage
`default_nettype wire

// file: verilog/asw_baud.sv
`timescale 1ns/10ps
`default_nettype none
module asw_baud
	import asw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [15:0] div,
	output logic tick
);
	logic [15:0] cnt_reg;

	// one pulse every div cycles: sixteen per bit
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_reg <= 16'h0000;
			tick <= 1'b0;
		end
		else if (cnt_reg + 16'h0001 >= div)
		begin
			cnt_reg <= 16'h0000;
			tick <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule // asw_baud
`default_nettype wire

// file: verilog/asw_tx.sv
`timescale 1ns/10ps
`default_nettype none
module asw_tx
	import asw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tick,
	input wire logic sender_on,
	input wire logic sbk,
	input wire logic nine,
	input wire logic buf_full,
	input wire logic [8:0] buf_data,
	output logic take,
	output logic busy,
	output logic txd_o,
	output logic txd_oe
);
	asw_tx_e state_reg;
	logic [10:0] sh_reg;
	logic [3:0] cnt_reg;
	logic [3:0] ph_reg;
	logic te_prev_reg;
	logic pre_reg;
	logic [3:0] len;
	logic bit_end;

	assign len = nine ? BITS9 + 4'h2 : BITS8 + 4'h2;
	assign bit_end = tick && ph_reg == OSR_LAST;
	assign busy = state_reg == TX_SHIFT;
	assign take = state_reg == TX_IDLE && !pre_reg && sender_on
		&& buf_full; // see (RULE8)
	assign txd_o = sh_reg[0]; // see (RULE1)
	assign txd_oe = busy | sender_on; // see (RULE9)

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			te_prev_reg <= 1'b0;
		else
			te_prev_reg <= sender_on;
	end

	// preamble request held until the shifter is free
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pre_reg <= 1'b0;
		else if (sender_on && !te_prev_reg)
			pre_reg <= 1'b1; // see (RULE19)
		else if (state_reg == TX_IDLE)
			pre_reg <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= TX_IDLE;
			sh_reg <= SH_IDLE;
			cnt_reg <= 4'h0;
			ph_reg <= 4'h0;
		end
		else
		begin
			case (state_reg)
				TX_IDLE:
				begin
					ph_reg <= 4'h0;
					cnt_reg <= len; // see (RULE17)
					if (pre_reg)
					begin
						sh_reg <= SH_IDLE; // see (RULE19)
						state_reg <= TX_SHIFT;
					end
					else if (take)
					begin
						// stop, data lsb first, start
						sh_reg <= nine ? {1'b1, buf_data, 1'b0}
							: {2'b11, buf_data[7:0], 1'b0}; // see (RULE2) (RULE3) (RULE4)
						state_reg <= TX_SHIFT;
					end
					else if (sbk && sender_on)
					begin
						// whole frame low, then the line rests high
						sh_reg <= nine ? 11'h000 : 11'h400; // see (RULE5) (RULE1)
						state_reg <= TX_SHIFT;
					end
				end
				TX_SHIFT:
				begin
					if (tick)
						ph_reg <= ph_reg + 4'h1;
					if (bit_end)
					begin
						sh_reg <= {1'b1, sh_reg[10:1]};
						cnt_reg <= cnt_reg - 4'h1;
						if (cnt_reg == 4'h1)
							state_reg <= TX_IDLE;
					end
				end
				default:
					state_reg <= TX_IDLE;
			endcase
		end
	end
endmodule // asw_tx
`default_nettype wire

// file: tb/asw_uart_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module asw_uart_monitor
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic txd_o,
	input wire logic txd_oe
);
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic rd_take;
	assign rd_take = hsel & hready & htrans[1] & ~hwrite;
	chk_ready_high: assert property (hreadyout)
		else $error("wait state inserted");
	chk_resp_okay: assert property (!hresp)
		else $error("error response");
	chk_rdata_hold: assert property (!$past(rd_take) |-> $stable(hrdata))
		else $error("read data moved without a read");
	chk_idle_high: assert property (!txd_oe |-> txd_o)
		else $error("undriven line not high");
	chk_start_len: assert property ($fell(txd_o) |=> !txd_o [*7])
		else $error("low bit too short");
	chk_high_len: assert property ($rose(txd_o) |=> txd_o [*7])
		else $error("high bit too short");
	chk_line_quiet: assert property (!txd_oe |-> $stable(txd_o))
		else $error("line moved while not driven");
	chk_preamble_high: assert property ($rose(txd_oe) |-> txd_o [*8])
		else $error("no idle preamble");
	cov_read: cover property (rd_take);
	cov_start: cover property ($fell(txd_o));
	cov_enable: cover property ($rose(txd_oe));
endmodule // asw_uart_monitor
bind asw_uart asw_uart_monitor u_asw_uart_monitor (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .txd_o(txd_o), .txd_oe(txd_oe));
`default_nettype wire

// file: tb/asw_remote.sv
`timescale 1ns/10ps
`default_nettype none
module asw_remote
(
	input wire logic hclk,
	input wire logic txd_o,
	input wire logic txd_oe,
	output logic rxd
);
	int bit_clks = 16;
	int nbits = 8;
	int got_count = 0;
	logic [8:0] got;
	logic got_stop;
	logic line;
	// pull-up holds the line when undriven
	assign line = txd_oe ? txd_o : 1'b1;
	initial rxd = 1'b1;
	task automatic send(input logic [8:0] d, input int glitch,
		input logic stop);
		int i;
		int k;
		for (i = -1; i <= nbits; i++)
		begin
			for (k = 0; k < bit_clks; k++)
			begin
				@(posedge hclk);
				if (i < 0)
					rxd <= 1'b0;
				else if (i == nbits)
					rxd <= stop;
				else
					rxd <= d[i] ^ (i == glitch && k == 9);
			end
		end
		@(posedge hclk);
		rxd <= 1'b1;
	endtask
	// samples mid-bit after a falling edge
	always
	begin
		int i;
		@(negedge line);
		got = 9'h000;
		repeat (bit_clks / 2) @(posedge hclk);
		for (i = 0; i <= nbits; i++)
		begin
			repeat (bit_clks) @(posedge hclk);
			if (i < nbits)
				got[i] = line;
			else
				got_stop = line;
		end
		got_count++;
	end
endmodule // asw_remote
`default_nettype wire

// file: tb/test_asw_uart.sv
`timescale 1ns/10ps
`default_nettype none
module test_asw_uart import asw_pkg::*;;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic rxd;
	logic txd_o;
	logic txd_oe;
	int fail_count = 0;
	int comparisons = 0;
	asw_uart u_asw_uart (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd_o(txd_o),
		.txd_oe(txd_oe));
	asw_remote u_asw_remote (.hclk(hclk), .txd_o(txd_o),
		.txd_oe(txd_oe), .rxd(rxd));
	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	task automatic end_of_test;
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
		begin
			fail_count++;
			end_of_test;
		end
	endtask
	task automatic bus(input logic wr, input logic [9:0] idx,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {20'h00000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask
	task automatic check(input logic [9:0] idx, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD reg %h expected %h seen %h", idx, exp, got);
		end
	endtask
	task automatic chk_line(input logic [9:0] exp);
		comparisons++;
		if ({u_asw_remote.got_stop, u_asw_remote.got} !== exp)
		begin
			fail_count++;
			$display("BAD line frame expected %h seen %h", exp,
				{u_asw_remote.got_stop, u_asw_remote.got});
		end
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask
	task automatic rd_chk(input logic [9:0] idx, input logic [31:0] mask,
		input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, idx, 32'h00000000, x);
		check(idx, exp, x & mask);
	endtask
	task automatic rx_get(input logic [31:0] st, input logic [31:0] d);
		rd_chk(IDX_STAT, 32'h0000002e, st);
		rd_chk(IDX_DATA, 32'hffffffff, d);
	endtask
	task automatic send(input logic [8:0] d, input int glitch);
		u_asw_remote.send(d, glitch, 1'b1);
		repeat (4) @(posedge hclk);
	endtask
	task automatic wait_tx(input int n);
		int k;
		for (k = 0; k < 4000 && u_asw_remote.got_count < n; k++)
			@(posedge hclk);
		if (u_asw_remote.got_count < n)
		begin
			fail_count++;
			end_of_test;
		end
	endtask
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(IDX_BAUD, 32'hffffffff, 32'h00000145);
		rd_chk(IDX_CTRL1, 32'hffffffff, 32'h00000000);
		rd_chk(IDX_CTRL2, 32'hffffffff, 32'h00000000);
		rd_chk(IDX_STAT, 32'hffffffff, 32'h000000c0);
		wr(10'h000, 32'hffffffff);
		rd_chk(10'h000, 32'hffffffff, 32'h00000000);
		wr(IDX_BAUD, 32'h00000001);
		rd_chk(IDX_BAUD, 32'h0000ffff, 32'h00000001);
		wr(IDX_CTRL2, 32'h0000000c);
		repeat (170) @(posedge hclk);
		wr(IDX_DATA, 32'h000000a5);
		// shifter takes the buffer one cycle after the write lands
		@(posedge hclk);
		rd_chk(IDX_STAT, 32'h00000080, 32'h00000080);
		wr(IDX_DATA, 32'h0000003c);
		rd_chk(IDX_STAT, 32'h00000080, 32'h00000000);
		wait_tx(1);
		chk_line(10'h2a5);
		wait_tx(2);
		chk_line(10'h23c);
		repeat (20) @(posedge hclk);
		rd_chk(IDX_STAT, 32'h000000c0, 32'h000000c0);
		send(9'h05a, -1);
		rx_get(32'h00000020, 32'h0000005a);
		rd_chk(IDX_STAT, 32'h00000020, 32'h00000000);
		send(9'h011, -1);
		send(9'h022, -1);
		rx_get(32'h00000028, 32'h00000011);
		send(9'h033, 2);
		rd_chk(IDX_STAT, 32'h00000024, 32'h00000024);
		rd_chk(IDX_DATA, 32'hffffffff, 32'h00000033);
		u_asw_remote.send(9'h000, -1, 1'b0);
		repeat (4) @(posedge hclk);
		rd_chk(IDX_BAUD, 32'h00010000, 32'h00010000);
		rx_get(32'h00000022, 32'h00000000);
		wr(IDX_CTRL1, 32'h00000050);
		u_asw_remote.nbits = 9;
		wr(IDX_DATA, 32'h00000081);
		wait_tx(3);
		chk_line(10'h381);
		send(9'h1c3, -1);
		rd_chk(IDX_CTRL1, 32'h00000080, 32'h00000080);
		rx_get(32'h00000020, 32'h000000c3);
		u_asw_remote.nbits = 8;
		wr(IDX_CTRL1, 32'h00000008);
		wr(IDX_CTRL2, 32'h0000000e);
		send(9'h012, -1);
		rd_chk(IDX_STAT, 32'h0000002e, 32'h00000000);
		rd_chk(IDX_CTRL2, 32'h0000000f, 32'h0000000e);
		send(9'h092, -1);
		rd_chk(IDX_CTRL2, 32'h0000000f, 32'h0000000c);
		rx_get(32'h00000020, 32'h00000092);
		wr(IDX_CTRL1, 32'h00000000);
		fork
			u_asw_remote.send(9'h044, -1, 1'b1);
			wr(IDX_CTRL2, 32'h0000000e);
		join
		rd_chk(IDX_STAT, 32'h00000020, 32'h00000000);
		rd_chk(IDX_CTRL2, 32'h0000000f, 32'h0000000e);
		repeat (170) @(posedge hclk);
		rd_chk(IDX_CTRL2, 32'h0000000f, 32'h0000000c);
		send(9'h055, -1);
		rx_get(32'h00000020, 32'h00000055);
		wr(IDX_CTRL2, 32'h0000000d);
		wait_tx(4);
		chk_line(10'h000);
		wr(IDX_CTRL2, 32'h0000000c);
		end_of_test;
	end
endmodule // test_asw_uart
`default_nettype wire
